// ===== design/psram_host.sv
// Host controller that drives an asynchronous pseudo-static memory
`timescale 1ns/100ps
module psram_host (
  // Clock, reset, enable
  input  wire logic                             i_clk_sys,
  input  wire logic                             i_rst,
  input  wire logic                             i_ce,
  // User request
  input  wire logic                             i_req_valid,
  output logic                                  o_req_ready,
  input  wire psram_host_pkg::request_t         i_req,
  // User read answer
  output logic                                  o_rdata_valid,
  output logic [psram_host_pkg::DATA_W-1:0]     o_rdata,
  // Memory pins
  output logic [psram_host_pkg::ADDR_W-1:0]     o_mem_addr,
  output psram_host_pkg::strobe_t               o_mem_strobe,
  input  wire logic [psram_host_pkg::DATA_W-1:0] i_mem_data,
  output logic [psram_host_pkg::DATA_W-1:0]     o_mem_data,
  output logic                                  o_mem_data_oe_n
);
  psram_host_pkg::state_t   state;
  psram_host_pkg::state_t   next_state;
  psram_host_pkg::request_t req;
  psram_host_pkg::strobe_t  next_strobe;
  logic                     phase_done;
  logic                     load;
  logic [psram_host_pkg::CNT_W-1:0] load_value;
  logic                     take;
  logic [1:0]               lane_use;

  //////////////////////////////////////////////////////////////////////////
  // Request acceptance and phase timing
  assign o_req_ready = (state == psram_host_pkg::ST_IDLE) && i_ce;
  assign take        = o_req_ready && i_req_valid;

  psram_cycle_counter u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_ce      (i_ce),
    .i_load    (load),
    .i_value   (load_value),
    .o_done    (phase_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // Next state and counter load
  always_comb begin
    next_state = state;
    load       = 1'b0;
    load_value = psram_host_pkg::READ_CNT;
    case (state)
      psram_host_pkg::ST_IDLE: begin
        if (take && i_req.write) begin
          next_state = psram_host_pkg::ST_TURN;
          load       = 1'b1;
          load_value = psram_host_pkg::TURN_CNT;
        end else if (take) begin
          next_state = psram_host_pkg::ST_READ;
          load       = 1'b1;
        end
      end
      psram_host_pkg::ST_READ: begin
        if (phase_done) next_state = psram_host_pkg::ST_IDLE;
      end
      psram_host_pkg::ST_TURN: begin
        if (phase_done) next_state = psram_host_pkg::ST_WSET;
      end
      psram_host_pkg::ST_WSET: begin
        next_state = psram_host_pkg::ST_WRITE;
        load       = 1'b1;
        load_value = psram_host_pkg::WRITE_CNT;
      end
      psram_host_pkg::ST_WRITE: begin
        if (phase_done) next_state = psram_host_pkg::ST_WEND;
      end
      psram_host_pkg::ST_WEND: next_state = psram_host_pkg::ST_IDLE;
      default: next_state = psram_host_pkg::ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin strobes for the next state; idle deselects the part
  always_comb begin
    next_strobe = psram_host_pkg::STROBE_IDLE;
    case (next_state)
      psram_host_pkg::ST_READ: begin
        next_strobe.chip_select_low_active  = 1'b0;
        next_strobe.chip_select_high_active = 1'b1;
        next_strobe.output_drive_n          = 1'b0;
        next_strobe.upper_byte_strobe_n     = ~lane_use[1];
        next_strobe.lower_byte_strobe_n     = ~lane_use[0];
      end
      psram_host_pkg::ST_TURN, psram_host_pkg::ST_WSET,
      psram_host_pkg::ST_WEND: begin
        // Selected, lanes set, write strobe high: no write under way
        next_strobe.chip_select_low_active  = 1'b0;
        next_strobe.chip_select_high_active = 1'b1;
        next_strobe.upper_byte_strobe_n     = ~lane_use[1];
        next_strobe.lower_byte_strobe_n     = ~lane_use[0];
      end
      psram_host_pkg::ST_WRITE: begin
        next_strobe.chip_select_low_active  = 1'b0;
        next_strobe.chip_select_high_active = 1'b1;
        // No lane asked for: write strobe stays high, nothing is stored
        next_strobe.write_strobe_n          = ~|lane_use;
        next_strobe.upper_byte_strobe_n     = ~lane_use[1];
        next_strobe.lower_byte_strobe_n     = ~lane_use[0];
      end
      default: next_strobe = psram_host_pkg::STROBE_IDLE;
    endcase
  end

  // Lanes come from the new request while idle, the held one after
  assign lane_use = (state == psram_host_pkg::ST_IDLE) ? i_req.lanes
                                                        : req.lanes;

  //////////////////////////////////////////////////////////////////////////
  // State, request hold and pins; address changes only while idle
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state           <= psram_host_pkg::ST_IDLE;
      req             <= '0;
      o_mem_addr      <= '0;
      o_mem_strobe    <= psram_host_pkg::STROBE_IDLE;
      o_mem_data      <= '0;
      o_mem_data_oe_n <= 1'b1;
    end else if (i_ce) begin
      state        <= next_state;
      o_mem_strobe <= next_strobe;
      if (take) begin
        req        <= i_req;
        o_mem_addr <= i_req.addr;
        o_mem_data <= i_req.wdata;
      end
      // Drive data only once output strobe has been high a full turn
      o_mem_data_oe_n <= !(next_state == psram_host_pkg::ST_WSET ||
                           next_state == psram_host_pkg::ST_WRITE ||
                           next_state == psram_host_pkg::ST_WEND);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data captured at the end of the read cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rdata       <= '0;
      o_rdata_valid <= 1'b0;
    end else if (i_ce) begin
      o_rdata_valid <= 1'b0;
      if (state == psram_host_pkg::ST_READ && phase_done) begin
        o_rdata       <= i_mem_data;
        o_rdata_valid <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sequence write_active_s;
    !o_mem_strobe.write_strobe_n;
  endsequence

  write_qual_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    write_active_s |-> !o_mem_strobe.chip_select_low_active &&
      o_mem_strobe.chip_select_high_active &&
      !(o_mem_strobe.upper_byte_strobe_n && o_mem_strobe.lower_byte_strobe_n))
    else $error("write strobe low without full select");

  write_end_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    $rose(o_mem_strobe.write_strobe_n) |-> !o_mem_strobe.chip_select_low_active
      && !o_mem_data_oe_n)
    else $error("write not ended by write strobe");

  data_hold_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    write_active_s |-> !o_mem_data_oe_n && $stable(o_mem_data))
    else $error("write data moved during write");

  addr_stable_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !o_mem_strobe.chip_select_low_active &&
      !$past(o_mem_strobe.chip_select_low_active) |-> $stable(o_mem_addr))
    else $error("address moved while selected");

  // A new address may only appear while the part was deselected
  addr_setup_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    $changed(o_mem_addr) |-> $past(o_mem_strobe.chip_select_low_active))
    else $error("address changed without deselect");

  read_len_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || !i_ce)
    $fell(o_mem_strobe.output_drive_n) |-> !o_mem_strobe.output_drive_n [*3]
      ##1 o_mem_strobe.chip_select_low_active)
    else $error("read cycle length wrong");

  read_pins_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    !o_mem_strobe.output_drive_n |-> o_mem_strobe.write_strobe_n &&
      o_mem_data_oe_n && !o_mem_strobe.chip_select_low_active)
    else $error("bad read strobes");

  write_oe_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    write_active_s |-> o_mem_strobe.output_drive_n)
    else $error("output strobe low during write");

  idle_pins_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    state == psram_host_pkg::ST_IDLE |-> o_mem_strobe ==
      psram_host_pkg::STROBE_IDLE)
    else $error("idle strobes wrong");

  turn_gap_a: assert property (
    @(posedge i_clk_sys) disable iff (i_rst || !i_ce)
    $fell(o_mem_data_oe_n) |-> $past(o_mem_strobe.output_drive_n, 2))
    else $error("data driven without turnaround");
endmodule

// ===== pkg/psram_host_pkg.sv
// Package for the pseudo-static memory host controller
package psram_host_pkg;
  localparam int unsigned ADDR_W     = 17;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned CLK_NS     = 25;
  // Bus timing of the slow speed grade, in ns
  localparam int unsigned READ_CYCLE_NS   = 70;
  localparam int unsigned WRITE_PULSE_NS  = 55;
  localparam int unsigned DATA_SETUP_NS   = 25;
  localparam int unsigned BUS_TURN_NS     = 25;
  localparam int unsigned ADDR_SKEW_NS    = 10;
  // Least times round up to whole cycles
  localparam int unsigned READ_CYC  = (READ_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WRITE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TURN_CYC  = (BUS_TURN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W     = 4;
  localparam logic [CNT_W-1:0] READ_CNT  = CNT_W'(READ_CYC);
  localparam logic [CNT_W-1:0] WRITE_CNT = CNT_W'(WRITE_CYC);
  localparam logic [CNT_W-1:0] TURN_CNT  = CNT_W'(TURN_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;

  // Pin strobes toward the memory
  typedef struct packed {
    logic chip_select_low_active;
    logic chip_select_high_active;
    logic write_strobe_n;
    logic output_drive_n;
    logic upper_byte_strobe_n;
    logic lower_byte_strobe_n;
  } strobe_t;

  localparam strobe_t STROBE_IDLE = 6'h3f & ~6'h10;

  // User request
  typedef struct packed {
    logic              write;
    logic [1:0]        lanes;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } request_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_READ  = 3'b001,
    ST_TURN  = 3'b010,
    ST_WSET  = 3'b011,
    ST_WRITE = 3'b100,
    ST_WEND  = 3'b101
  } state_t;
endpackage

// ===== design/psram_cycle_counter.sv
// Down counter that times one bus phase
`timescale 1ns/100ps
module psram_cycle_counter (
  // Clock and control
  input  wire logic                            i_clk_sys,
  input  wire logic                            i_rst,
  input  wire logic                            i_ce,
  input  wire logic                            i_load,
  input  wire logic [psram_host_pkg::CNT_W-1:0] i_value,
  // Status
  output logic                                 o_done
);
  logic [psram_host_pkg::CNT_W-1:0] count;

  // Load wins over counting
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      count <= psram_host_pkg::CNT_ZERO;
    end else if (i_ce) begin
      if (i_load) begin
        count <= i_value;
      end else if (count != psram_host_pkg::CNT_ZERO) begin
        count <= count - psram_host_pkg::CNT_ONE;
      end
    end
  end

  assign o_done = (count <= psram_host_pkg::CNT_ONE) && !i_load;
endmodule

// ===== testbench/psram_device_model.sv
// Behavioural pseudo-static memory as seen from the host pins
`timescale 1ns/100ps
module psram_device_model (
  // Host pins
  input  wire logic [psram_host_pkg::ADDR_W-1:0] i_addr,
  input  wire psram_host_pkg::strobe_t           i_strobe,
  input  wire logic [psram_host_pkg::DATA_W-1:0] i_bus,
  // Device drive toward the bus
  output logic [psram_host_pkg::DATA_W-1:0]      o_data,
  output logic [1:0]                             o_lane_drv
);
  logic [15:0] mem [0:131071];
  logic        sel;
  logic        wr;
  logic        rd;
  logic [1:0]  lanes;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode from the pin levels
  assign lanes = ~{i_strobe.upper_byte_strobe_n, i_strobe.lower_byte_strobe_n};
  assign sel = !i_strobe.chip_select_low_active
    && i_strobe.chip_select_high_active && lanes != 2'b00;
  assign wr = sel && !i_strobe.write_strobe_n;
  assign rd = sel && i_strobe.write_strobe_n
    && !i_strobe.output_drive_n;
  assign o_lane_drv = rd ? lanes : 2'b00;
  assign o_data = mem[i_addr];

  ////////////////////////////////////////////////////////////////////////////
  // Store follows the bus while the overlap lasts, so the last value wins
  always @(wr or lanes or i_bus or i_addr) begin
    if (wr && lanes[0])
      mem[i_addr][7:0] = i_bus[7:0];
    if (wr && lanes[1])
      mem[i_addr][15:8] = i_bus[15:8];
  end
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the memory host controller
`timescale 1ns/100ps
module tb_top;
  logic clk = 0, rst = 1, ce = 1, req_valid = 0;
  psram_host_pkg::request_t req = '0;
  psram_host_pkg::strobe_t  strobe;
  logic        rdv, rdy, oe_n;
  logic [15:0] rdata, hdata, dev, bus, flt = 16'h5a3c;
  logic [16:0] addr;
  logic [1:0]  drv;
  logic [31:0] r;
  int          n_mismatch = 0, checks = 0, seed = 32'h0dc8c106;
  logic [15:0] shadow [8];
  logic [16:0] atab [8] = '{17'h00000, 17'h1ffff, 17'h00001, 17'h10000,
                            17'h0aaaa, 17'h15555, 17'h00100, 17'h1fffe};

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Bus level; a released lane shows a pattern, not a stale value
  always @(posedge clk) flt <= ~flt + 16'h1357;
  assign bus[7:0]  = !oe_n ? hdata[7:0] : drv[0] ? dev[7:0] : flt[7:0];
  assign bus[15:8] = !oe_n ? hdata[15:8] : drv[1] ? dev[15:8] : flt[15:8];

  psram_host psram_host_i (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce),
    .i_req_valid(req_valid), .o_req_ready(rdy), .i_req(req),
    .o_rdata_valid(rdv), .o_rdata(rdata), .o_mem_addr(addr),
    .o_mem_strobe(strobe), .i_mem_data(bus), .o_mem_data(hdata),
    .o_mem_data_oe_n(oe_n));
  psram_device_model psram_device_model_i (.i_addr(addr), .i_strobe(strobe),
    .i_bus(bus), .o_data(dev), .o_lane_drv(drv));

  ////////////////////////////////////////////////////////////////////////////
  // Shared compare, expectation and transfer tasks
  task automatic check(input string nm, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [15:0] merge(logic [15:0] o, d, logic [1:0] ln);
    logic [15:0] m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    return (o & ~m) | (d & m);
  endfunction

  task automatic access(input logic w, input logic [1:0] ln, input int i,
                        input logic [15:0] d);
    int n;
    logic [15:0] m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    req_valid = 1;
    req = '{w, ln, atab[i], d};
    n = 0;
    // Ready is judged settled, off the edge; the next edge is the take
    while (rdy !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("req_ready", 1, rdy);
    @(posedge clk);
    #1;
    req_valid = 0;
    check("mem_addr", atab[i], addr);
    if (w) begin
      shadow[i] = merge(shadow[i], d, ln);
      return;
    end
    check("read_strobes", {1'b0, ~ln}, {strobe.output_drive_n,
      strobe.upper_byte_strobe_n, strobe.lower_byte_strobe_n});
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rdv !== 1'b1 && n < 20);
    check("read_latency", psram_host_pkg::READ_CYC, n);
    check("read_data", shadow[i] & m, rdata & m);
  endtask

  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Pin monitor, sampled on pre-edge values so no race with the design
  always @(posedge clk) begin
    if (rst === 1'b0) begin
      check("bus_contention", 0, !oe_n && drv != 2'b00);
      if (rdy === 1'b1)
        check("idle_strobes", psram_host_pkg::STROBE_IDLE, strobe);
      if (strobe.write_strobe_n === 1'b0)
        check("write_output_off", 1, strobe.output_drive_n);
    end
  end

  // Run is about 1250 cycles; this cut-off leaves wide margin
  initial begin
    #500000;
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst = 0;
    // Full words at boundary and ordinary addresses
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      access(1, 2'b11, i, r[15:0]);
    end
    for (int i = 0; i < 8; i++) access(0, 2'b11, i, 16'h0);
    $display("test fill done");
    // Every lane code written, then read back at once
    for (int k = 0; k < 4; k++) begin
      access(1, k[1:0], 1, 16'ha5c3 ^ k[15:0]);
      access(0, 2'b11, 1, 16'h0);
    end
    $display("test lanes done");
    // A frozen enable must leave a pending request untaken
    ce = 0;
    req_valid = 1;
    req = '{1'b0, 2'b11, atab[0], 16'h0};
    repeat (5) begin
      @(posedge clk);
      #1;
      check("frozen_ready", 0, rdy);
      check("frozen_idle", psram_host_pkg::STROBE_IDLE, strobe);
    end
    // Withdraw the request with the enable so the next edge takes nothing
    req_valid = 0;
    ce = 1;
    @(posedge clk);
    #1;
    access(0, 2'b01, 0, 16'h0);
    $display("test enable done");
    // Random mix of reads and writes over all lane codes
    repeat (200) begin
      r = $random(seed);
      access(r[0], r[2:1], int'(r[5:3]), r[31:16]);
    end
    $display("test random done");
    conclude();
  end
endmodule
